// [verilog/vrir_consts.svh]
// constants of the vibration record info register bank
// assumes 7-bit byte addresses and 16-bit serial frames
`ifndef VRIR_CONSTS_SVH
`define VRIR_CONSTS_SVH

// register byte addresses, even byte holds bits 7:0
`define VRIR_ADDR_ALARM_PEAK   7'h4a
`define VRIR_ADDR_TIME_LOW     7'h4c
`define VRIR_ADDR_TIME_HIGH    7'h4e
`define VRIR_ADDR_BUILD_DAY_FIRMWARE_REV      7'h52
`define VRIR_ADDR_YEAR_MONTH   7'h54
`define VRIR_ADDR_PRODUCT      7'h56
`define VRIR_ADDR_SERIAL       7'h58
`define VRIR_ADDR_USER_TAG     7'h5a
`define VRIR_ADDR_FLASH_WEAR   7'h5c
`define VRIR_ADDR_MISC_CTRL    7'h64
`define VRIR_ADDR_SPEC_INFO    7'h66

// serial frame fields
`define VRIR_FRM_WRITE_BIT     15
`define VRIR_FRM_ADDR_MSB      14
`define VRIR_FRM_ADDR_LSB      8
`define VRIR_FRM_LAST_BIT      4'hf

// control register bit positions, within the 16-bit word
`define VRIR_MISC_SYNC_EN      12
`define VRIR_MISC_STAT_LOAD    10
`define VRIR_MISC_STAT_STORE   9
`define VRIR_MISC_STAT_CLEAR   8
`define VRIR_MISC_SELFTEST_ON  3
`define VRIR_MISC_SELFTEST_OFF 2
`define VRIR_BYTE_WIDTH        8

// reset values
`define VRIR_RST_WORD          16'h0000
`define VRIR_RST_SLOTS         4'h0
`define VRIR_RECORD_SLOTS      10

`endif

// [verilog/vrir_pkg.sv]
// types shared by the register bank and its serial link
// assumes the constants header is compiled alongside
package vrir_pkg;
    typedef logic [15:0] vrir_word_t;
    typedef logic [6:0]  vrir_addr_t;
    typedef logic [7:0]  vrir_byte_t;
    // direction of a completed serial frame
    typedef enum logic {
        VRIR_FRAME_READ,
        VRIR_FRAME_WRITE
    } vrir_frame_e;
endpackage : vrir_pkg

// [verilog/vrir_link_if.sv]
// carrier between the serial shifter and the register bank
// assumes both ends run on the same reference clock
`timescale 1ns/1ns
`default_nettype none
interface vrir_link_if;
    import vrir_pkg::*;
    logic       frame_done; // one-cycle pulse, word complete
    vrir_word_t rx_word;    // received frame
    vrir_word_t tx_word;    // answer for the next frame
    modport phy (
        output frame_done,
        output rx_word,
        input  tx_word
    );
    modport regs (
        input  frame_done,
        input  rx_word,
        output tx_word
    );
endinterface : vrir_link_if
`default_nettype wire

// [verilog/vrir_spi_link.sv]
// serial shifter: samples on rising clock, shifts out on falling
// assumes serial clock well below a quarter of the reference clock
`timescale 1ns/1ns
`default_nettype none
`include "vrir_consts.svh"
module vrir_spi_link (
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rst_n,
    // serial pins, asynchronous to clk
    input  wire logic   sclk,
    input  wire logic   cs_n,
    input  wire logic   din,
    output logic        dout,
    // toward the register bank
    vrir_link_if.phy    link
);
    import vrir_pkg::*;

    logic       sclk_s1_q, sclk_s2_q, sclk_s3_q;
    logic       cs_s1_q, cs_s2_q, cs_s3_q;
    logic       din_s1_q, din_s2_q;
    vrir_word_t rx_q, rx_d, tx_q, tx_d, word_q, word_d;
    logic [3:0] bits_q, bits_d;
    logic       done_q, done_d;
    logic       rise, fall, cs_fall, active;

    // edges come from the second and third stages only
    assign rise    = sclk_s2_q & ~sclk_s3_q;
    assign fall    = ~sclk_s2_q & sclk_s3_q;
    assign cs_fall = ~cs_s2_q & cs_s3_q;
    assign active  = ~cs_s2_q;

    // shift state; answer is loaded once per select
    always_comb begin
        rx_d   = rx_q;
        tx_d   = tx_q;
        bits_d = bits_q;
        word_d = word_q;
        done_d = 1'b0;
        if (cs_fall) begin
            tx_d   = link.tx_word;
            bits_d = 4'h0;
            rx_d   = `VRIR_RST_WORD;
        end else if (active && rise) begin
            rx_d   = {rx_q[14:0], din_s2_q};
            bits_d = bits_q + 4'h1;
            if (bits_q == `VRIR_FRM_LAST_BIT) begin
                done_d = 1'b1;
                word_d = {rx_q[14:0], din_s2_q};
            end
        end else if (active && fall && bits_q != 4'h0) begin
            tx_d = {tx_q[14:0], 1'b0}; // first bit stands from select
        end
    end

    // synchronisers and shift registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_s1_q <= 1'b1;
            sclk_s2_q <= 1'b1;
            sclk_s3_q <= 1'b1;
            cs_s1_q   <= 1'b1;
            cs_s2_q   <= 1'b1;
            cs_s3_q   <= 1'b1;
            din_s1_q  <= 1'b0;
            din_s2_q  <= 1'b0;
            rx_q      <= `VRIR_RST_WORD;
            tx_q      <= `VRIR_RST_WORD;
            word_q    <= `VRIR_RST_WORD;
            bits_q    <= 4'h0;
            done_q    <= 1'b0;
        end else begin
            sclk_s1_q <= sclk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            cs_s1_q   <= cs_n;
            cs_s2_q   <= cs_s1_q;
            cs_s3_q   <= cs_s2_q;
            din_s1_q  <= din;
            din_s2_q  <= din_s1_q;
            rx_q      <= rx_d;
            tx_q      <= tx_d;
            word_q    <= word_d;
            bits_q    <= bits_d;
            done_q    <= done_d;
        end
    end

    assign dout            = tx_q[15];
    assign link.rx_word    = word_q;
    assign link.frame_done = done_q;
endmodule : vrir_spi_link
`default_nettype wire

// [verilog/vrir_regs.sv]
// vibration record info register bank behind the serial port
// assumes processing core inputs share REF_CLK; pins are asynchronous
// a read is answered in the serial frame after the request
// storage, sync capture and statistics engines sit outside
//
// Contract
// - alarm peak magnitude is a 16-bit read-only word in sample format.
// - capture time in seconds is read as a low and a high 16-bit word.
// - day and revision word holds two day digits then two revision digits.
// - year and month word holds two year digits then two month digits.
// - product number is a fixed read-only 16-bit binary value.
// - unit serial is a fixed read-only 16-bit value.
// - user tag is read-write over 16 bits and restored from storage after reset.
// - wear counter steps once on record clearing and once when all 10 slots fill.
// - control bit 12 lets sync pin activity start a capture.
// - control bit 10 loads a statistics record chosen by the record pointer.
// - control bit 9 stores current statistics into a flash record.
// - control bit 8 clears the accumulated statistics.
// - control bit 3 turns self-test stimulus on and bit 2 turns it off.
// - spectral info bits 15:14 give rate option and 13:12 give window.
// - spectral info low byte gives the number of spectral averages.
`timescale 1ns/1ns
`default_nettype none
`include "vrir_consts.svh"
module vrir_regs #(
    parameter logic [15:0] PRODUCT_NUMBER   = 16'h0001, // arbitrary value
    parameter logic [15:0] UNIT_SERIAL      = 16'h0000,
    parameter logic [15:0] BUILD_BUILD_DAY_FIRMWARE_REV    = 16'h0000,
    parameter logic [15:0] BUILD_YEAR_MONTH = 16'h0000,
    parameter logic [3:0]  RECORD_SLOTS     = 4'(`VRIR_RECORD_SLOTS)
) (
    // clock and reset
    input  wire logic          REF_CLK,
    input  wire logic          RESETN,
    // serial port pins
    input  wire logic          SCLK,
    input  wire logic          CS_N,
    input  wire logic          DIN,
    output logic               DOUT,
    // live values from the processing core
    input  wire vrir_pkg::vrir_word_t ALARM_PEAK_IN,
    input  wire vrir_pkg::vrir_word_t TIME_LOW_IN,
    input  wire vrir_pkg::vrir_word_t TIME_HIGH_IN,
    input  wire logic [1:0]    RATE_OPTION_IN,
    input  wire logic [1:0]    WINDOW_IN,
    input  wire logic [7:0]    AVERAGES_IN,
    // record storage events, one-cycle pulses
    input  wire logic          RECORD_STORED,
    input  wire logic          RECORDS_CLEARED,
    // nonvolatile user tag storage
    input  wire vrir_pkg::vrir_word_t USER_TAG_NV,
    output vrir_pkg::vrir_word_t USER_TAG_OUT,
    output logic               USER_TAG_SAVE,
    // external trigger pin, asynchronous
    input  wire logic          SYNC_PIN,
    output logic               SYNC_ENABLE,
    output logic               CAPTURE_START,
    // statistics and self-test controls
    output logic               STAT_LOAD,
    output logic               STAT_STORE,
    output logic               STAT_CLEAR,
    output logic               SELF_TEST_ON
);
    import vrir_pkg::*;

    // carrier to the shifter, which owns serial pin synchronisation
    vrir_link_if link ();

    // word-level hit, shared by the read mux and the write decode
    // bit 0 is ignored so either byte address reaches the word
    function automatic logic vrir_hit(input vrir_addr_t addr, input vrir_addr_t base);
        vrir_hit = (addr[6:1] == base[6:1]);
    endfunction : vrir_hit

    // serial shifter; SCLK, CS_N and DIN are read nowhere else
    vrir_spi_link u_link (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .sclk  (SCLK),
        .cs_n  (CS_N),
        .din   (DIN),
        .dout  (DOUT),
        .link  (link.phy)
    );

    // frame decode
    // fields mean something only while frame_done is high;
    // between frames the word holds the last frame received
    // odd byte addresses select the upper byte of a word
    vrir_frame_e kind;
    vrir_addr_t  addr;
    vrir_byte_t  wdata;
    logic        wr_lo, wr_hi;
    assign kind  = link.rx_word[`VRIR_FRM_WRITE_BIT] ? VRIR_FRAME_WRITE : VRIR_FRAME_READ;
    assign addr  = link.rx_word[`VRIR_FRM_ADDR_MSB:`VRIR_FRM_ADDR_LSB];
    assign wdata = link.rx_word[`VRIR_BYTE_WIDTH-1:0];
    assign wr_lo = link.frame_done && kind == VRIR_FRAME_WRITE && !addr[0];
    assign wr_hi = link.frame_done && kind == VRIR_FRAME_WRITE && addr[0];

    // state of the bank
    // slots_q counts filled record locations, zero after a clear
    // restore_q is high only up to the first edge after reset
    vrir_word_t resp_q, resp_d;
    vrir_word_t tag_q, tag_d;
    logic       restore_q, restore_d;
    logic       tag_save_q, tag_save_d;
    vrir_word_t wear_q, wear_d;
    logic [3:0] slots_q, slots_d;
    logic       sync_en_q, sync_en_d;
    logic       selftest_q, selftest_d;
    logic       load_q, load_d;
    logic       store_q, store_d;
    logic       clear_q, clear_d;
    logic       capture_q, capture_d;
    logic       sync_s1_q, sync_s2_q, sync_s3_q;
    vrir_word_t read_word;
    vrir_word_t misc_view;
    vrir_word_t info_view;

    // readable views of control and spectral info
    // unused spectral bits read zero rather than floating
    assign misc_view = {3'h0, sync_en_q, 12'h000}; // command bits read zero
    assign info_view = {RATE_OPTION_IN, WINDOW_IN, 4'h0, AVERAGES_IN};

    // read mux; unmapped words answer zero
    // live inputs are taken as they stand at frame end
    // limitation: a timestamp read as two words may tear
    always_comb begin
        read_word = `VRIR_RST_WORD;
        if (vrir_hit(addr, `VRIR_ADDR_ALARM_PEAK)) begin
            read_word = ALARM_PEAK_IN;
        end else if (vrir_hit(addr, `VRIR_ADDR_TIME_LOW)) begin
            read_word = TIME_LOW_IN;
        end else if (vrir_hit(addr, `VRIR_ADDR_TIME_HIGH)) begin
            read_word = TIME_HIGH_IN;
        end else if (vrir_hit(addr, `VRIR_ADDR_BUILD_DAY_FIRMWARE_REV)) begin
            read_word = BUILD_BUILD_DAY_FIRMWARE_REV;
        end else if (vrir_hit(addr, `VRIR_ADDR_YEAR_MONTH)) begin
            read_word = BUILD_YEAR_MONTH;
        end else if (vrir_hit(addr, `VRIR_ADDR_PRODUCT)) begin
            read_word = PRODUCT_NUMBER;
        end else if (vrir_hit(addr, `VRIR_ADDR_SERIAL)) begin
            read_word = UNIT_SERIAL;
        end else if (vrir_hit(addr, `VRIR_ADDR_USER_TAG)) begin
            read_word = tag_q;
        end else if (vrir_hit(addr, `VRIR_ADDR_FLASH_WEAR)) begin
            read_word = wear_q;
        end else if (vrir_hit(addr, `VRIR_ADDR_MISC_CTRL)) begin
            read_word = misc_view;
        end else if (vrir_hit(addr, `VRIR_ADDR_SPEC_INFO)) begin
            read_word = info_view;
        end
    end

    // answer latched at end of any frame, shifted out in the next one
    // a write frame reloads the answer too, so reads are repeated
    // after a write to see the word that was asked for
    always_comb begin
        resp_d = resp_q;
        if (link.frame_done) begin
            resp_d = read_word;
        end
    end
    assign link.tx_word = resp_q;

    // user tag: restore once after reset, then byte writes
    // restore wins, though no frame can complete that early
    // one save pulse per byte written; storage must keep up
    always_comb begin
        tag_d      = tag_q;
        restore_d  = 1'b0;
        tag_save_d = 1'b0;
        if (restore_q) begin
            tag_d = USER_TAG_NV;
        end else if (vrir_hit(addr, `VRIR_ADDR_USER_TAG) && (wr_lo || wr_hi)) begin
            if (wr_lo) begin
                tag_d[7:0] = wdata;
            end else begin
                tag_d[15:8] = wdata;
            end
            tag_save_d = 1'b1; // storage keeps the last written value
        end
    end

    // wear counter; clearing wins over a store in the same cycle
    // slot count tracks fills only, not the record pointer
    // wear wraps at the top of its 16 bits, no saturation
    always_comb begin
        wear_d  = wear_q;
        slots_d = slots_q;
        if (RECORDS_CLEARED) begin
            slots_d = `VRIR_RST_SLOTS;
            wear_d  = wear_q + 16'h0001;
        end else if (RECORD_STORED) begin
            if (slots_q == RECORD_SLOTS) begin
                slots_d = 4'h1; // full bank reuses slots from the start
            end else begin
                slots_d = slots_q + 4'h1;
            end
            if (slots_q == RECORD_SLOTS - 4'h1) begin
                wear_d = wear_q + 16'h0001;
            end
        end
    end

    // control register: sync enable and self-test levels and self-clearing commands
    // commands are one-cycle pulses; a zero written does nothing
    // self test is a level held until the off bit is written
    always_comb begin
        sync_en_d  = sync_en_q;
        selftest_d = selftest_q;
        load_d     = 1'b0;
        store_d    = 1'b0;
        clear_d    = 1'b0;
        if (vrir_hit(addr, `VRIR_ADDR_MISC_CTRL) && wr_hi) begin
            sync_en_d = wdata[`VRIR_MISC_SYNC_EN - `VRIR_BYTE_WIDTH];
            load_d    = wdata[`VRIR_MISC_STAT_LOAD - `VRIR_BYTE_WIDTH];
            store_d   = wdata[`VRIR_MISC_STAT_STORE - `VRIR_BYTE_WIDTH];
            clear_d   = wdata[`VRIR_MISC_STAT_CLEAR - `VRIR_BYTE_WIDTH];
        end
        if (vrir_hit(addr, `VRIR_ADDR_MISC_CTRL) && wr_lo) begin
            // off wins when both bits are written together
            if (wdata[`VRIR_MISC_SELFTEST_OFF]) begin
                selftest_d = 1'b0;
            end else if (wdata[`VRIR_MISC_SELFTEST_ON]) begin
                selftest_d = 1'b1;
            end
        end
    end

    // sync pin rising edge starts a capture only while enabled
    // third stage serves the edge detector only
    // limitation: pin pulses under one clock may be missed
    always_comb begin
        capture_d = sync_en_q && sync_s2_q && !sync_s3_q;
    end

    // all state registers
    // reset loads constants only; the tag waits for restore_q
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            resp_q     <= `VRIR_RST_WORD;
            tag_q      <= `VRIR_RST_WORD;
            restore_q  <= 1'b1;
            tag_save_q <= 1'b0;
            wear_q     <= `VRIR_RST_WORD;
            slots_q    <= `VRIR_RST_SLOTS;
            sync_en_q  <= 1'b0;
            selftest_q <= 1'b0;
            load_q     <= 1'b0;
            store_q    <= 1'b0;
            clear_q    <= 1'b0;
            capture_q  <= 1'b0;
            sync_s1_q  <= 1'b0;
            sync_s2_q  <= 1'b0;
            sync_s3_q  <= 1'b0;
        end else begin
            resp_q     <= resp_d;
            tag_q      <= tag_d;
            restore_q  <= restore_d;
            tag_save_q <= tag_save_d;
            wear_q     <= wear_d;
            slots_q    <= slots_d;
            sync_en_q  <= sync_en_d;
            selftest_q <= selftest_d;
            load_q     <= load_d;
            store_q    <= store_d;
            clear_q    <= clear_d;
            capture_q  <= capture_d;
            sync_s1_q  <= SYNC_PIN;
            sync_s2_q  <= sync_s1_q;
            sync_s3_q  <= sync_s2_q;
        end
    end

    // outputs, all from flops
    // pulses are registered, so the core needs no edge detector
    assign USER_TAG_OUT  = tag_q;
    assign USER_TAG_SAVE = tag_save_q;
    assign SYNC_ENABLE   = sync_en_q;
    assign CAPTURE_START = capture_q;
    assign STAT_LOAD     = load_q;
    assign STAT_STORE    = store_q;
    assign STAT_CLEAR    = clear_q;
    assign SELF_TEST_ON  = selftest_q;
endmodule : vrir_regs
`default_nettype wire

// [dv/vrir_regs_assertions.sv]
// concurrent checks on the record info register bank ports
// assumes binding onto vrir_regs; one clock, async active-low reset
`timescale 1ns/1ns
`default_nettype none
module vrir_regs_assertions (
    // clock and reset
    input wire logic                 REF_CLK,
    input wire logic                 RESETN,
    // watched pins
    input wire logic                 CS_N,
    input wire logic                 SYNC_PIN,
    input wire logic                 SYNC_ENABLE,
    input wire logic                 CAPTURE_START,
    input wire logic                 STAT_LOAD,
    input wire logic                 STAT_STORE,
    input wire logic                 STAT_CLEAR,
    input wire logic                 SELF_TEST_ON,
    input wire vrir_pkg::vrir_word_t USER_TAG_OUT,
    input wire logic                 USER_TAG_SAVE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    // trigger edge while external capture is allowed
    sequence sync_edge_s;
        $rose(SYNC_PIN) && SYNC_ENABLE;
    endsequence
    // deselected long enough for any frame to have landed
    sequence idle_s;
        CS_N [*6];
    endsequence
    chk_sync_start: assert property (sync_edge_s |-> ##[1:5] CAPTURE_START)
        else $error("capture did not follow sync edge");
    chk_start_single: assert property (CAPTURE_START |=> !CAPTURE_START [*8])
        else $error("capture pulse repeated");
    chk_no_spur_start: assert property (!SYNC_ENABLE [*8] |-> !CAPTURE_START)
        else $error("capture while sync disabled");
    chk_load_single: assert property (STAT_LOAD |=> !STAT_LOAD [*8])
        else $error("load command acted twice");
    chk_store_single: assert property (STAT_STORE |=> !STAT_STORE [*8])
        else $error("store command acted twice");
    chk_clear_single: assert property (STAT_CLEAR |=> !STAT_CLEAR [*8])
        else $error("clear command acted twice");
    chk_idle_quiet: assert property (idle_s |-> $stable(SYNC_ENABLE) && $stable(SELF_TEST_ON)
        && $stable(USER_TAG_OUT) && !(STAT_LOAD || STAT_STORE || STAT_CLEAR || USER_TAG_SAVE))
        else $error("control changed with port idle");
    chk_save_single: assert property (USER_TAG_SAVE |=> !USER_TAG_SAVE)
        else $error("tag save pulse too long");
    chk_tag_saved: assert property ($changed(USER_TAG_OUT) && $past(RESETN, 2) |-> ##[0:1] USER_TAG_SAVE)
        else $error("tag changed without save");
endmodule : vrir_regs_assertions
bind vrir_regs vrir_regs_assertions vrir_regs_assertions_i (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .CS_N(CS_N), .SYNC_PIN(SYNC_PIN),
    .SYNC_ENABLE(SYNC_ENABLE), .CAPTURE_START(CAPTURE_START), .STAT_LOAD(STAT_LOAD),
    .STAT_STORE(STAT_STORE), .STAT_CLEAR(STAT_CLEAR), .SELF_TEST_ON(SELF_TEST_ON),
    .USER_TAG_OUT(USER_TAG_OUT), .USER_TAG_SAVE(USER_TAG_SAVE)
);
`default_nettype wire

// [dv/vrir_host_model.sv]
// host controller model: serial master, clock idles high
// assumes the bank samples at clock rise; half period kept at 6 clocks
`timescale 1ns/1ns
`default_nettype none
module vrir_host_model (
    // reference clock
    input  wire logic clk,
    // serial pins
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout
);
    localparam int HALF = 6; // above the 4-clock floor of the synchronisers
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b0;
    end
    // one 16-bit frame; data moves on falls, answer taken at rises
    task xfer(input logic [15:0] tx, output logic [15:0] rx);
        @(posedge clk);
        cs_n <= 1'b0;
        din  <= tx[15];
        repeat (HALF) @(posedge clk);
        for (int i = 15; i >= 0; i--) begin
            sclk <= 1'b0;
            din  <= tx[i];
            repeat (HALF) @(posedge clk);
            sclk  <= 1'b1;
            rx[i] = dout;
            repeat (HALF) @(posedge clk);
        end
        cs_n <= 1'b1;
        // idle gap; data line toggles so a stale bit is never mistaken for data
        repeat (8) @(posedge clk) din <= ~din;
    endtask : xfer
endmodule : vrir_host_model
`default_nettype wire

// [dv/vrir_regs_tb.sv]
// self-checking bench for the record info register bank
// assumes the host model drives the serial pins; one 100 MHz clock
`timescale 1ns/1ns
`default_nettype none
module vrir_regs_tb;
    import vrir_pkg::*;
    localparam vrir_word_t PROD   = 16'h0001; // arbitrary value
    localparam vrir_word_t SERIAL = 16'h0042;
    localparam vrir_word_t DAYREV = 16'h2713;
    localparam vrir_word_t YRMON  = 16'h2411;
    localparam logic [7:0] ST_CMD [4] = '{8'h08, 8'h04, 8'h08, 8'h0c};
    logic        ref_clk, resetn, sclk, cs_n, din, dout, rec_stored, recs_cleared;
    logic        sync_pin, tag_save, sync_en, cap, ld, st, cl, st_on;
    logic [1:0]  rate, win;
    logic [7:0]  avg;
    logic [31:0] seed;
    vrir_word_t  alarm, t_lo, t_hi, tag_nv, tag_out, rd, v;
    int          miscompares, tests_run, cycles, wear_exp, slots_exp;
    int          npulse [5];
    vrir_regs #(.PRODUCT_NUMBER(PROD), .UNIT_SERIAL(SERIAL), .BUILD_BUILD_DAY_FIRMWARE_REV(DAYREV),
        .BUILD_YEAR_MONTH(YRMON)) vrir_regs_i (
        .REF_CLK(ref_clk), .RESETN(resetn), .SCLK(sclk), .CS_N(cs_n), .DIN(din), .DOUT(dout),
        .ALARM_PEAK_IN(alarm), .TIME_LOW_IN(t_lo), .TIME_HIGH_IN(t_hi),
        .RATE_OPTION_IN(rate), .WINDOW_IN(win), .AVERAGES_IN(avg),
        .RECORD_STORED(rec_stored), .RECORDS_CLEARED(recs_cleared),
        .USER_TAG_NV(tag_nv), .USER_TAG_OUT(tag_out), .USER_TAG_SAVE(tag_save),
        .SYNC_PIN(sync_pin), .SYNC_ENABLE(sync_en), .CAPTURE_START(cap),
        .STAT_LOAD(ld), .STAT_STORE(st), .STAT_CLEAR(cl), .SELF_TEST_ON(st_on));
    vrir_host_model vrir_host_model_i (.clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout));
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;
    // pulse counts; a stuck level shows as a count far too high
    always @(posedge ref_clk) begin
        cycles++;
        npulse[0] += ld;
        npulse[1] += st;
        npulse[2] += cl;
        npulse[3] += cap;
        npulse[4] += tag_save;
        if (cycles == 30000) begin
            miscompares++;
            stop_test();
        end
    end
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xorshift
    function automatic vrir_word_t spec_word(logic [1:0] r, logic [1:0] w, logic [7:0] a);
        return {r, w, 4'h0, a};
    endfunction : spec_word
    task check(input string what, input vrir_word_t seen, input vrir_word_t exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task wr(input vrir_addr_t a, input vrir_byte_t d);
        vrir_host_model_i.xfer({1'b1, a, d}, rd);
    endtask : wr
    // answer arrives in the frame after the request
    task rdreg(input vrir_addr_t a, output vrir_word_t data);
        vrir_host_model_i.xfer({1'b0, a, 8'h00}, data);
        vrir_host_model_i.xfer({1'b0, a, 8'h00}, data);
    endtask : rdreg
    task store(input int n);
        repeat (n) begin
            @(posedge ref_clk) rec_stored <= 1'b1;
            @(posedge ref_clk) rec_stored <= 1'b0;
            if (slots_exp == 10) slots_exp = 1;
            else begin
                slots_exp++;
                if (slots_exp == 10) wear_exp++;
            end
        end
    endtask : store
    task sync_edge();
        @(posedge ref_clk) sync_pin <= 1'b1;
        repeat (10) @(posedge ref_clk);
        sync_pin <= 1'b0;
        repeat (10) @(posedge ref_clk);
    endtask : sync_edge
    task stop_test();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    initial begin
        seed = 32'd88002;
        {resetn, rec_stored, recs_cleared, sync_pin, rate, win, avg} = '0;
        {alarm, t_lo, t_hi} = '0;
        tag_nv = 16'(xorshift());
        repeat (10) @(posedge ref_clk);
        check("quiet in reset", {8'h00, ld, st, cl, st_on, sync_en, cap, tag_save, dout}, 16'h0000);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("tag restored", tag_out, tag_nv);
        rdreg(7'h5a, rd); check("tag read", rd, tag_nv);
        rdreg(7'h64, rd); check("control reset", rd, 16'h0000);
        rdreg(7'h5c, rd); check("wear reset", rd, 16'h0000);
        // every rate and window code with fresh live values
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            alarm <= 16'(xorshift());
            t_lo  <= 16'(xorshift());
            t_hi  <= 16'(xorshift());
            avg   <= 8'(xorshift());
            rate  <= 2'(i);
            win   <= 2'(3 - i);
            rdreg(7'h4a, rd); check("alarm peak", rd, alarm);
            rdreg(7'h4c, rd); check("time low", rd, t_lo);
            rdreg(7'h4f, rd); check("time high", rd, t_hi);
            // fields taken as valid here, as for a spectral record
            rdreg(7'h66, rd); check("spectral info", rd, spec_word(rate, win, avg));
        end
        rdreg(7'h52, rd); check("build_day_firmware_rev", rd, DAYREV);
        rdreg(7'h55, rd); check("year month", rd, YRMON);
        rdreg(7'h58, rd); check("serial", rd, SERIAL);
        wr(7'h56, 8'hff);
        rdreg(7'h57, rd); check("product fixed", rd, PROD);
        rdreg(7'h60, rd); check("unmapped", rd, 16'h0000);
        v = 16'(xorshift());
        wr(7'h5a, v[7:0]);
        wr(7'h5b, v[15:8]);
        check("tag out", tag_out, v);
        check("tag saves", 16'(npulse[4]), 16'h0002);
        rdreg(7'h5b, rd); check("tag read back", rd, v);
        wr(7'h65, 8'h10);
        rdreg(7'h64, rd); check("sync enable read", rd, 16'h1000);
        check("sync enable pin", {15'h0, sync_en}, 16'h0001);
        sync_edge();
        wr(7'h65, 8'h07);
        wr(7'h65, 8'h00);
        sync_edge();
        check("pulses", {4'(npulse[0]), 4'(npulse[1]), 4'(npulse[2]), 4'(npulse[3])}, 16'h1111);
        rdreg(7'h65, rd); check("control reads zero", rd, 16'h0000);
        // on, off, on, then both bits where off wins
        for (int i = 0; i < 4; i++) begin
            wr(7'h64, ST_CMD[i]);
            check("self test", {15'h0, st_on}, 16'(~i & 1));
        end
        store(3);
        @(posedge ref_clk) recs_cleared <= 1'b1;
        @(posedge ref_clk) recs_cleared <= 1'b0;
        wear_exp++;
        slots_exp = 0;
        store(10);
        rdreg(7'h5c, rd); check("wear filled", rd, 16'(wear_exp));
        store(10);
        rdreg(7'h5d, rd); check("wear refilled", rd, 16'(wear_exp));
        // clear and store together: clear wins, slots restart
        @(posedge ref_clk) {rec_stored, recs_cleared} <= 2'b11;
        @(posedge ref_clk) {rec_stored, recs_cleared} <= 2'b00;
        wear_exp++;
        slots_exp = 0;
        store(10);
        rdreg(7'h5c, rd); check("wear clear wins", rd, 16'(wear_exp));
        stop_test();
    end
endmodule : vrir_regs_tb
`default_nettype wire
